// >>> hw/banked_data_memory_addressing.sv
/*
 * Data memory address generation and storage: bank pointer, access window,
 * full-address moves, general storage and the special-area decode.
 * Assumes the core gives one-cycle strobes for its second and fourth quarters,
 * on this clock, and holds its request steady through the instruction cycle.
 */
// Contract
// RQ1: every data location has a 12-bit byte address, 4096 bytes in all.
// RQ2: sixteen banks of 256 bytes; bank is upper bits, offset lower.
// RQ3: all sixteen banks exist; general storage below, special registers on top.
// RQ4: reading a location with no storage behind it returns zero.
// RQ5: banked address is bank pointer on top of the 8-bit operand.
// RQ6: bank pointer keeps four low bits; upper four read zero, ignore writes.
// RQ7: load-bank-literal puts its literal straight into the bank pointer.
// RQ8: banked write to F9h with bank 0Fh hits program counter low.
// RQ9: unimplemented bank writes dropped, reads zero, flags still updated.
// RQ10: full-address move uses 12-bit source and destination, ignores bank pointer.
// RQ11: access window is bank 0 00h-5Fh then bank 15 60h-FFh.
// RQ12: access-select one uses bank pointer plus operand.
// RQ13: access-select zero uses access window, bank pointer ignored.
// RQ14: access window access finishes in one cycle, no bank update needed.
// RQ15: extended set enabled changes the access map; supplied from outside.
// RQ16: operand read in second quarter, destination written in fourth quarter.
// RQ17: general storage is never initialised and survives resets.
// RQ18: access operands below 60h map to 000h-05Fh, others to F60h-FFFh.
// RQ19: bank pointer resets to zero.
`timescale 1ns/1ps
module banked_data_memory_addressing #(
    parameter logic [dmem_pkg::NUM_BANKS-1:0] IMPL_BANKS = dmem_pkg::ALL_BANKS
) (
    input  wire logic                        sys_clk_i,
    input  wire logic                        reset_n_i,
    input  wire dmem_pkg::core_req_type      req_i,
    input  wire logic                        second_quarter_clock_i,
    input  wire logic                        fourth_quarter_clock_i,
    input  wire logic                        extended_set_enable_i,
    input  wire logic [dmem_pkg::ADDR_W-1:0] ext_addr_i,
    input  wire logic [dmem_pkg::DATA_W-1:0] special_rdata_i,
    input  wire logic                        special_hit_i,
    output logic      [dmem_pkg::ADDR_W-1:0] special_raddr_o,
    output logic      [dmem_pkg::DATA_W-1:0] rd_data_o,
    output logic      [dmem_pkg::ADDR_W-1:0] rd_addr_o,
    output logic      [dmem_pkg::DATA_W-1:0] bank_pointer_o,
    output dmem_pkg::special_wr_type         special_wr_o,
    output logic                             program_counter_low_wr_o,
    output logic                             flags_update_o,
    output logic                             wr_dropped_o
);
    logic [dmem_pkg::BANK_W-1:0] bank_ptr_q;
    logic [dmem_pkg::BANK_W-1:0] bank_ptr_d;
    logic [dmem_pkg::DATA_W-1:0] rd_data_q;
    logic [dmem_pkg::ADDR_W-1:0] rd_addr_q;
    dmem_pkg::special_wr_type    special_wr_q;
    dmem_pkg::special_wr_type    special_wr_d;
    logic                        pc_low_wr_q;
    logic                        flags_update_q;
    logic                        wr_dropped_q;

    logic [dmem_pkg::ADDR_W-1:0] rd_addr;
    logic [dmem_pkg::ADDR_W-1:0] wr_addr;
    dmem_pkg::addr_src_type      rd_src;
    dmem_pkg::addr_src_type      wr_src;
    logic [dmem_pkg::DATA_W-1:0] general_rdata;

    wire                        rd_bank_ok;
    wire                        rd_general;
    wire                        rd_bank_reg;
    wire [dmem_pkg::DATA_W-1:0] rd_value;
    wire                        wr_fire;
    wire                        wr_bank_ok;
    wire                        wr_general;
    wire                        wr_bank_reg;
    wire                        wr_special;
    wire                        wr_pc_low;
    wire                        load_lit;

    // source operand address, formed in the same cycle as the read
    effective_address_former rd_former (
        .op_addr_i    (req_i.op_addr),
        .access_sel_i (req_i.access_sel),
        .full_move_i  (req_i.full_move),
        .full_addr_i  (req_i.full_src),
        .bank_ptr_i   (bank_ptr_q),
        .ext_enable_i (extended_set_enable_i),
        .ext_addr_i   (ext_addr_i),
        .addr_o       (rd_addr),
        .src_o        (rd_src)
    );

    // destination address; full moves take the separate destination word
    effective_address_former wr_former (
        .op_addr_i    (req_i.op_addr),
        .access_sel_i (req_i.access_sel),
        .full_move_i  (req_i.full_move),
        .full_addr_i  (req_i.full_dst),
        .bank_ptr_i   (bank_ptr_q),
        .ext_enable_i (extended_set_enable_i),
        .ext_addr_i   (ext_addr_i),
        .addr_o       (wr_addr),
        .src_o        (wr_src)
    );

    general_storage storage (
        .sys_clk_i (sys_clk_i),
        .wr_i      (wr_general),
        .waddr_i   (wr_addr),
        .wdata_i   (req_i.wr_data),
        .raddr_i   (rd_addr),
        .rdata_o   (general_rdata)
    );

    // read side decode
    assign rd_bank_ok  = IMPL_BANKS[rd_addr[dmem_pkg::ADDR_W-1:dmem_pkg::OFS_W]]; // RQ3
    assign rd_general  = rd_addr <= dmem_pkg::GENERAL_TOP;
    assign rd_bank_reg = rd_addr == dmem_pkg::BANK_PTR_ADDR;

    // holes in the special area and missing banks read as zero
    assign rd_value = !rd_bank_ok    ? dmem_pkg::ZERO_BYTE :                        // RQ9
                      rd_general     ? general_rdata :
                      rd_bank_reg    ? {dmem_pkg::BANK_PTR_UNUSED, bank_ptr_q} :   // RQ6
                      special_hit_i  ? special_rdata_i : dmem_pkg::ZERO_BYTE;      // RQ4

    assign special_raddr_o = rd_addr;

    // write side decode, only in the fourth quarter
    assign wr_fire     = fourth_quarter_clock_i && req_i.wr_en; // RQ16
    assign wr_bank_ok  = IMPL_BANKS[wr_addr[dmem_pkg::ADDR_W-1:dmem_pkg::OFS_W]];
    assign wr_general  = wr_fire && wr_bank_ok && (wr_addr <= dmem_pkg::GENERAL_TOP);
    assign wr_bank_reg = wr_fire && wr_bank_ok && (wr_addr == dmem_pkg::BANK_PTR_ADDR);
    assign wr_special  = wr_fire && wr_bank_ok && (wr_addr >= dmem_pkg::SPECIAL_BASE);
    assign wr_pc_low   = wr_special && (wr_addr == dmem_pkg::PC_LOW_ADDR); // RQ8
    assign load_lit    = fourth_quarter_clock_i && req_i.load_bank;

    // literal load wins if both ever arrive together; upper bits dropped
    assign bank_ptr_d = load_lit    ? req_i.literal[dmem_pkg::BANK_W-1:0] :  // RQ7
                        wr_bank_reg ? req_i.wr_data[dmem_pkg::BANK_W-1:0] :  // RQ6
                                      bank_ptr_q;

    assign special_wr_d = '{wr:    wr_special,
                            addr:  wr_addr,
                            wdata: req_i.wr_data};

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            bank_ptr_q <= dmem_pkg::BANK_PTR_RESET; // RQ19
        end else begin
            bank_ptr_q <= bank_ptr_d;
        end
    end

    // operand captured in the second quarter; one cycle, no bank update first
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            rd_data_q <= dmem_pkg::ZERO_BYTE;
            rd_addr_q <= '0;
        end else if (second_quarter_clock_i) begin
            rd_data_q <= rd_value; // RQ16 RQ14
            rd_addr_q <= rd_addr;
        end
    end

    // flags go out whether or not the bank exists
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            special_wr_q   <= '0;
            pc_low_wr_q    <= 1'b0;
            flags_update_q <= 1'b0;
            wr_dropped_q   <= 1'b0;
        end else begin
            special_wr_q   <= special_wr_d;
            pc_low_wr_q    <= wr_pc_low;
            flags_update_q <= fourth_quarter_clock_i && req_i.data_op; // RQ9
            wr_dropped_q   <= wr_fire && !wr_bank_ok;                 // RQ9
        end
    end

    assign rd_data_o                = rd_data_q;
    assign rd_addr_o                = rd_addr_q;
    assign bank_pointer_o           = {dmem_pkg::BANK_PTR_UNUSED, bank_ptr_q};
    assign special_wr_o             = special_wr_q;
    assign program_counter_low_wr_o = pc_low_wr_q;
    assign flags_update_o           = flags_update_q;
    assign wr_dropped_o             = wr_dropped_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_read_q2;
        second_quarter_clock_i && !req_i.full_move;
    endsequence

    sequence s_write_q4;
        fourth_quarter_clock_i && req_i.wr_en;
    endsequence

    sequence s_write_landed;
        s_write_q4 ##0 wr_bank_ok;
    endsequence

    sequence s_write_missing;
        s_write_q4 ##0 !wr_bank_ok;
    endsequence

    AST_BANK_UPPER_ZERO: assert property ( // RQ6
        bank_pointer_o[dmem_pkg::DATA_W-1:dmem_pkg::BANK_W] == dmem_pkg::BANK_PTR_UNUSED)
        else $error("bank pointer upper bits not zero");

    AST_LOAD_LITERAL: assert property ( // RQ7
        fourth_quarter_clock_i && req_i.load_bank
        |=> bank_pointer_o[dmem_pkg::BANK_W-1:0] == $past(req_i.literal[dmem_pkg::BANK_W-1:0]))
        else $error("literal not loaded into bank pointer");

    AST_BANK_RESET: assert property ( // RQ19
        disable iff (1'b0) !reset_n_i |=> bank_pointer_o == dmem_pkg::ZERO_BYTE)
        else $error("bank pointer not zero after reset");

    AST_BANKED_ADDR: assert property ( // RQ12
        s_read_q2 ##0 req_i.access_sel
        |=> rd_addr_o == {$past(bank_ptr_q), $past(req_i.op_addr)})
        else $error("banked address wrong");

    AST_ACCESS_LOW: assert property ( // RQ18
        s_read_q2 ##0 (!req_i.access_sel && !extended_set_enable_i
                       && req_i.op_addr < dmem_pkg::ACCESS_SPLIT)
        |=> rd_addr_o[dmem_pkg::ADDR_W-1:dmem_pkg::OFS_W] == dmem_pkg::ACCESS_LOW_BANK)
        else $error("low access window not in bank 0");

    AST_ACCESS_HIGH: assert property ( // RQ11
        s_read_q2 ##0 (!req_i.access_sel && !extended_set_enable_i
                       && req_i.op_addr >= dmem_pkg::ACCESS_SPLIT)
        |=> rd_addr_o == {dmem_pkg::ACCESS_HIGH_BANK, $past(req_i.op_addr)})
        else $error("high access window not in bank 15");

    AST_FULL_MOVE: assert property ( // RQ10
        second_quarter_clock_i && req_i.full_move |=> rd_addr_o == $past(req_i.full_src))
        else $error("full move address used bank pointer");

    AST_UNIMPL_READ: assert property ( // RQ9
        second_quarter_clock_i && !rd_bank_ok |=> rd_data_o == dmem_pkg::ZERO_BYTE)
        else $error("unimplemented bank read not zero");

    AST_PC_LOW: assert property ( // RQ8
        s_write_q4 ##0 (!req_i.full_move && req_i.access_sel
                        && bank_ptr_q == dmem_pkg::ACCESS_HIGH_BANK
                        && req_i.op_addr == dmem_pkg::PC_LOW_ADDR[dmem_pkg::OFS_W-1:0])
        |=> program_counter_low_wr_o && special_wr_o.addr == dmem_pkg::PC_LOW_ADDR)
        else $error("program counter low write missed");

    AST_FLAGS: assert property ( // RQ9
        fourth_quarter_clock_i && req_i.data_op |=> flags_update_o)
        else $error("flags update missing");

    AST_READ_HOLD: assert property ( // RQ16
        !second_quarter_clock_i |=> $stable(rd_data_o) && $stable(rd_addr_o))
        else $error("read data changed outside second quarter");

    AST_BANK_WRITE: assert property ( // RQ6
        s_write_landed ##0 (!req_i.load_bank && wr_addr == dmem_pkg::BANK_PTR_ADDR)
        |=> bank_pointer_o == {dmem_pkg::BANK_PTR_UNUSED,
                               $past(req_i.wr_data[dmem_pkg::BANK_W-1:0])})
        else $error("bank pointer write wrong");

    AST_WR_DROPPED: assert property ( // RQ9
        s_write_missing |=> wr_dropped_o && !special_wr_o.wr)
        else $error("write to missing bank not discarded");

    AST_WR_KEPT: assert property ( // RQ9
        s_write_landed |=> !wr_dropped_o)
        else $error("write to present bank reported dropped");

    AST_SPECIAL_WR: assert property ( // RQ3
        s_write_landed ##0 (wr_addr >= dmem_pkg::SPECIAL_BASE)
        |=> special_wr_o.wr && special_wr_o.addr == $past(wr_addr)
            && special_wr_o.wdata == $past(req_i.wr_data))
        else $error("special area write not forwarded");

    AST_GENERAL_WR: assert property ( // RQ3
        s_write_q4 ##0 (wr_addr <= dmem_pkg::GENERAL_TOP) |=> !special_wr_o.wr)
        else $error("general storage write forwarded as special");

    AST_PULSE_Q4: assert property ( // RQ16
        !fourth_quarter_clock_i
        |=> !special_wr_o.wr && !program_counter_low_wr_o && !wr_dropped_o && !flags_update_o)
        else $error("write pulse outside fourth quarter");

    AST_BANK_HOLD: assert property ( // RQ7
        !fourth_quarter_clock_i |=> $stable(bank_pointer_o))
        else $error("bank pointer changed outside fourth quarter");

    AST_HOLE_ZERO: assert property ( // RQ4
        second_quarter_clock_i && rd_bank_ok && rd_addr >= dmem_pkg::SPECIAL_BASE
        && !rd_bank_reg && !special_hit_i |=> rd_data_o == dmem_pkg::ZERO_BYTE)
        else $error("unimplemented special location not zero");

    AST_SPECIAL_READ: assert property ( // RQ16
        second_quarter_clock_i && rd_bank_ok && rd_addr >= dmem_pkg::SPECIAL_BASE
        && !rd_bank_reg && special_hit_i
        |=> rd_data_o == $past(special_rdata_i))
        else $error("special register read data lost");

    AST_EXT_MAP: assert property ( // RQ15
        s_read_q2 ##0 (!req_i.access_sel && extended_set_enable_i)
        |=> rd_addr_o == $past(ext_addr_i))
        else $error("extended access map address not used");

endmodule

// >>> hw/dmem_pkg.sv
/*
 * Shared constants and carrier types for the banked data memory addressing block.
 * Assumes a core datapath on the same clock that marks its quarter phases with strobes.
 */
package dmem_pkg;

    localparam int ADDR_W        = 12;
    localparam int DATA_W        = 8;
    localparam int BANK_W        = 4;
    localparam int OFS_W         = 8;
    localparam int NUM_BANKS     = 16;
    localparam int BANK_BYTES    = 256;
    localparam int GENERAL_BYTES = 3904;

    localparam logic [OFS_W-1:0]  ACCESS_SPLIT     = 8'h60;
    localparam logic [BANK_W-1:0] ACCESS_LOW_BANK  = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [BANK_W-1:0] BANK_PTR_RESET   = 4'h0;
    localparam logic [BANK_W-1:0] BANK_PTR_UNUSED  = 4'h0;

    localparam logic [ADDR_W-1:0] GENERAL_TOP   = 12'hf3f;
    localparam logic [ADDR_W-1:0] SPECIAL_BASE  = 12'hf40;
    localparam logic [ADDR_W-1:0] BANK_PTR_ADDR = 12'hfe0;
    localparam logic [ADDR_W-1:0] PC_LOW_ADDR   = 12'hff9;

    localparam logic [DATA_W-1:0]    ZERO_BYTE = 8'h00;
    localparam logic [NUM_BANKS-1:0] ALL_BANKS = 16'hffff;

    typedef enum logic [1:0] {
        SRC_BANKED,
        SRC_ACCESS,
        SRC_FULL,
        SRC_EXTENDED
    } addr_src_type;

    typedef struct packed {
        logic [OFS_W-1:0]  op_addr;
        logic              access_sel;
        logic              full_move;
        logic [ADDR_W-1:0] full_src;
        logic [ADDR_W-1:0] full_dst;
        logic              data_op;
        logic              wr_en;
        logic [DATA_W-1:0] wr_data;
        logic              load_bank;
        logic [DATA_W-1:0] literal;
    } core_req_type;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } special_wr_type;

endpackage

// >>> hw/effective_address_former.sv
/*
 * Forms the 12-bit data address from an operand, the bank pointer, the access map
 * or a full address. Purely combinational; the caller registers what it needs.
 */
`timescale 1ns/1ps
module effective_address_former (
    input  wire logic [dmem_pkg::OFS_W-1:0]  op_addr_i,
    input  wire logic                        access_sel_i,
    input  wire logic                        full_move_i,
    input  wire logic [dmem_pkg::ADDR_W-1:0] full_addr_i,
    input  wire logic [dmem_pkg::BANK_W-1:0] bank_ptr_i,
    input  wire logic                        ext_enable_i,
    input  wire logic [dmem_pkg::ADDR_W-1:0] ext_addr_i,
    output logic      [dmem_pkg::ADDR_W-1:0] addr_o,
    output dmem_pkg::addr_src_type           src_o
);
    wire                        access_high;
    wire [dmem_pkg::ADDR_W-1:0] access_addr;
    wire [dmem_pkg::ADDR_W-1:0] banked_addr;

    // window: low part of bank 0 then high part of bank 15, linear in the operand
    assign access_high = op_addr_i >= dmem_pkg::ACCESS_SPLIT; // RQ11
    assign access_addr = access_high ? {dmem_pkg::ACCESS_HIGH_BANK, op_addr_i}
                                     : {dmem_pkg::ACCESS_LOW_BANK, op_addr_i}; // RQ18
    assign banked_addr = {bank_ptr_i, op_addr_i}; // RQ2 RQ5

    // full moves never look at the bank pointer; access mode ignores it too
    assign src_o = full_move_i  ? dmem_pkg::SRC_FULL :     // RQ10
                   access_sel_i ? dmem_pkg::SRC_BANKED :   // RQ12
                   ext_enable_i ? dmem_pkg::SRC_EXTENDED : // RQ15
                                  dmem_pkg::SRC_ACCESS;    // RQ13

    assign addr_o = (src_o == dmem_pkg::SRC_FULL)     ? full_addr_i :
                    (src_o == dmem_pkg::SRC_BANKED)   ? banked_addr :
                    (src_o == dmem_pkg::SRC_EXTENDED) ? ext_addr_i  : access_addr; // RQ1

endmodule

// >>> hw/general_storage.sv
/*
 * General storage array below the special register area.
 * Assumes the caller only writes addresses up to the general top.
 */
`timescale 1ns/1ps
module general_storage (
    input  wire logic                        sys_clk_i,
    input  wire logic                        wr_i,
    input  wire logic [dmem_pkg::ADDR_W-1:0] waddr_i,
    input  wire logic [dmem_pkg::DATA_W-1:0] wdata_i,
    input  wire logic [dmem_pkg::ADDR_W-1:0] raddr_i,
    output logic      [dmem_pkg::DATA_W-1:0] rdata_o
);
    // no reset on purpose: contents survive every reset
    logic [dmem_pkg::DATA_W-1:0] mem [0:dmem_pkg::GENERAL_BYTES-1];

    wire raddr_ok;

    assign raddr_ok = raddr_i <= dmem_pkg::GENERAL_TOP;
    assign rdata_o  = raddr_ok ? mem[raddr_i] : dmem_pkg::ZERO_BYTE;

    always_ff @(posedge sys_clk_i) begin
        if (wr_i) begin
            mem[waddr_i] <= wdata_i; // RQ17
        end
    end

endmodule

// >>> verification/core_phase_model.sv
/*
 * Core-side partner: quarter strobes of the instruction cycle and the
 * special-register answer. Assumes one clock and a synchronous low reset.
 */
`timescale 1ns/1ps
module core_phase_model (
    input  wire logic                        sys_clk_i,
    input  wire logic                        reset_n_i,
    input  wire logic [dmem_pkg::ADDR_W-1:0] special_raddr_i,
    output logic                             q2_o,
    output logic                             q4_o,
    output logic      [dmem_pkg::DATA_W-1:0] special_rdata_o,
    output logic                             special_hit_o
);
    logic [1:0] phase_q;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            phase_q <= 2'h0;
            q2_o    <= 1'b0;
            q4_o    <= 1'b0;
        end else begin
            phase_q <= phase_q + 2'h1;
            q2_o    <= (phase_q == 2'h0);
            q4_o    <= (phase_q == 2'h2);
        end
    end

    // only program counter low exists; holes answer junk so zeroing is visible
    assign special_hit_o   = (special_raddr_i == dmem_pkg::PC_LOW_ADDR);
    assign special_rdata_o = special_hit_o ? 8'hc3 : ~special_raddr_i[7:0];
endmodule

// >>> verification/banked_data_memory_addressing_tb_top.sv
/*
 * Self-checking bench for the banked data memory addressing block.
 * Assumes the core partner model sets the quarter strobes.
 */
`timescale 1ns/1ps
module banked_data_memory_addressing_tb_top;
    logic                     sys_clk  = 1'b0;
    logic                     reset_n  = 1'b0;
    dmem_pkg::core_req_type   req      = '0;
    logic                     ext_en   = 1'b0;
    logic                     ext_sel  = 1'b0;
    logic [11:0]              ext_addr = 12'h0a5;
    logic                     q2, q4, hit, pc_wr, flags, dropped;
    logic [7:0]               srd, rd_data, bank_ptr;
    logic [11:0]              sraddr, rd_addr;
    dmem_pkg::special_wr_type swr;
    int                       fails = 0;
    int                       checks_done = 0;

    always #20 sys_clk = ~sys_clk;

    // bank 2 left out to reach the discard path
    banked_data_memory_addressing #(.IMPL_BANKS(16'hfffb)) i_dut (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .req_i(req),
        .second_quarter_clock_i(q2), .fourth_quarter_clock_i(q4),
        .extended_set_enable_i(ext_en), .ext_addr_i(ext_addr),
        .special_rdata_i(srd), .special_hit_i(hit), .special_raddr_o(sraddr),
        .rd_data_o(rd_data), .rd_addr_o(rd_addr), .bank_pointer_o(bank_ptr),
        .special_wr_o(swr), .program_counter_low_wr_o(pc_wr),
        .flags_update_o(flags), .wr_dropped_o(dropped)
    );

    core_phase_model i_core (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .special_raddr_i(sraddr),
        .q2_o(q2), .q4_o(q4), .special_rdata_o(srd), .special_hit_o(hit)
    );

    task automatic check(input string what, input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic dmem_pkg::core_req_type mk(input logic [7:0] op, input logic acc,
                                                  input logic we, input logic [7:0] wd);
        dmem_pkg::core_req_type r;
        r = '0;
        r.op_addr = op;
        r.access_sel = acc;
        r.wr_en = we;
        r.wr_data = wd;
        r.data_op = 1'b1;
        return r;
    endfunction

    // applied on an edge, held through the write edge; returns mid-cycle after it,
    // so the write pulses and the read data both stand when looked at
    task automatic step(input dmem_pkg::core_req_type r);
        int n;
        n = 0;
        @(posedge sys_clk);
        req    <= r;
        ext_en <= ext_sel;
        do begin
            @(negedge sys_clk);
            n++;
        end while (q4 !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            $display("MISMATCH quarter strobe never came");
        end
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic load_bank(input logic [7:0] lit);
        dmem_pkg::core_req_type r;
        r = mk(8'h00, 1'b0, 1'b0, 8'h00);
        r.load_bank = 1'b1;
        r.literal = lit;
        step(r);
    endtask

    task automatic t_load_bank();
        check("bank after reset", bank_ptr, 12'h000);
        load_bank(8'hf3);
        check("bank loaded", bank_ptr, 12'h003);
        step(mk(8'he0, 1'b0, 1'b0, 8'h00));
        check("bank mirror addr", rd_addr, 12'hfe0);
        check("bank mirror data", rd_data, 12'h003);
    endtask

    task automatic t_banked();
        step(mk(8'h21, 1'b1, 1'b1, 8'h5c));
        check("flags", flags, 12'h001);
        check("not dropped", dropped, 12'h000);
        check("special wr", swr.wr, 12'h000);
        step(mk(8'h21, 1'b1, 1'b0, 8'h00));
        check("banked addr", rd_addr, 12'h321);
        check("banked data", rd_data, 12'h05c);
    endtask

    task automatic t_access();
        step(mk(8'h21, 1'b0, 1'b1, 8'h77));
        step(mk(8'h21, 1'b0, 1'b0, 8'h00));
        check("access addr", rd_addr, 12'h021);
        check("access data", rd_data, 12'h077);
        step(mk(8'h21, 1'b1, 1'b0, 8'h00));
        check("banked kept", rd_data, 12'h05c);
        step(mk(8'h5f, 1'b0, 1'b0, 8'h00));
        check("access low top", rd_addr, 12'h05f);
        step(mk(8'h60, 1'b0, 1'b0, 8'h00));
        check("access high base", rd_addr, 12'hf60);
        check("hole reads zero", rd_data, 12'h000);
    endtask

    task automatic t_pc_low();
        load_bank(8'h0f);
        step(mk(8'hf9, 1'b1, 1'b1, 8'h3c));
        check("pc low pulse", pc_wr, 12'h001);
        check("special addr", swr.addr, 12'hff9);
        check("special data", swr.wdata, 12'h03c);
        step(mk(8'hf9, 1'b0, 1'b0, 8'h00));
        check("pc low pulse ends", pc_wr, 12'h000);
        check("special read", rd_data, 12'h0c3);
        check("special raddr", sraddr, 12'hff9);
    endtask

    task automatic t_missing();
        load_bank(8'h02);
        step(mk(8'h10, 1'b1, 1'b1, 8'haa));
        check("dropped", dropped, 12'h001);
        check("flags kept", flags, 12'h001);
        step(mk(8'h10, 1'b1, 1'b0, 8'h00));
        check("missing addr", rd_addr, 12'h210);
        check("missing data", rd_data, 12'h000);
    endtask

    task automatic t_full();
        dmem_pkg::core_req_type r;
        // the core carries the moved byte as write data
        r = mk(8'h00, 1'b1, 1'b1, 8'h5c);
        r.full_move = 1'b1;
        r.full_src = 12'h321;
        r.full_dst = 12'h122;
        step(r);
        check("full src addr", rd_addr, 12'h321);
        check("full src data", rd_data, 12'h05c);
        r.wr_en = 1'b0;
        r.full_src = 12'h122;
        step(r);
        check("full dst data", rd_data, 12'h05c);
    endtask

    task automatic t_bank_write();
        step(mk(8'he0, 1'b0, 1'b1, 8'hff));
        check("bank upper ignored", bank_ptr, 12'h00f);
        ext_sel = 1'b1;
        step(mk(8'h33, 1'b0, 1'b0, 8'h00));
        check("extended map addr", rd_addr, 12'h0a5);
        ext_sel = 1'b0;
    endtask

    task automatic t_retention();
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        step('0);
        check("bank after rereset", bank_ptr, 12'h000);
        step(mk(8'h21, 1'b0, 1'b0, 8'h00));
        check("storage kept", rd_data, 12'h077);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        step('0);
        t_load_bank();
        t_banked();
        t_access();
        t_pc_low();
        t_missing();
        t_full();
        t_bank_write();
        t_retention();
        finish_test();
    end

    // about 28 instruction cycles expected; far more allowed
    initial begin
        #400000;
        fails++;
        $display("MISMATCH watchdog ran out");
        finish_test();
    end
endmodule
